// File: hdl/tfcp_pkg.sv
/*
 * constants, codes and carrier types for the tape formatter command port.
 * assumes a 200 MHz core clock; host lines are taken as active high here, formatter select as active low.
 */
`default_nettype none
package tfcp_pkg;
  // clock and timing
  localparam int CLK_NS = 5;
  localparam int WS_LO_WIDTH_NS = 1000; // 50 ips strobe width
  localparam int WS_LO_PERIOD_NS = 2000;
  localparam int WS_HI_WIDTH_NS = 400; // 100 ips strobe width
  localparam int WS_HI_PERIOD_NS = 1000;
  localparam int FIRST_DATA_NS = 10000; // first character window
  localparam int WS_LO_WIDTH = (WS_LO_WIDTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int WS_LO_PERIOD = (WS_LO_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int WS_HI_WIDTH = (WS_HI_WIDTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int WS_HI_PERIOD = (WS_HI_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int FIRST_DATA = FIRST_DATA_NS / CLK_NS;
  localparam int LONG_GAP_MILS = 300; // extra gap over nominal
  // register offsets and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam int CTRL_ONLINE = 2;
  localparam int CTRL_LOADED = 3;
  localparam logic [1:0] UNIT_SW_RST = 2'h0;
  // command codes, bit4 down to bit0
  localparam logic [4:0] C_READ_FWD = 5'h00;
  localparam logic [4:0] C_READ_REV = 5'h08;
  localparam logic [4:0] C_READ_SENSE = 5'h19;
  localparam logic [4:0] C_WRITE = 5'h04;
  localparam logic [4:0] C_WRITE_MARK = 5'h06;
  localparam logic [4:0] C_WRITE_EXT = 5'h0e;
  localparam logic [4:0] C_ERASE_CTL = 5'h05;
  localparam logic [4:0] C_ERASE_FIX = 5'h07;
  localparam logic [4:0] C_ERASE_SEC = 5'h17;
  localparam logic [4:0] C_SPACE_FWD = 5'h01;
  localparam logic [4:0] C_SPACE_REV = 5'h09;
  localparam logic [4:0] C_SEARCH_FWD = 5'h03;
  localparam logic [4:0] C_SEARCH_REV = 5'h0b;
  localparam logic [4:0] C_SEL_PE = 5'h13;
  localparam logic [4:0] C_SEL_GCR = 5'h1b;
  localparam logic [4:0] C_DIAG_INVOKE = 5'h0c;
  localparam logic [4:0] C_DIAG_LOOP_WR = 5'h0f;
  localparam logic [4:0] C_DIAG_STAT_SEQ = 5'h10;
  localparam logic [4:0] C_DIAG_WRAP = 5'h11;
  localparam logic [4:0] C_DIAG_EXT_SENSE = 5'h1d;
  localparam logic [4:0] C_DIAG_LOOPBACK = 5'h1f;

  typedef enum logic [4:0] {
    OP_READ_FWD, OP_READ_REV, OP_READ_SENSE, OP_WRITE, OP_WRITE_MARK,
    OP_WRITE_EXT, OP_ERASE_CTL, OP_ERASE_FIX, OP_ERASE_SEC, OP_SPACE_FWD,
    OP_SPACE_REV, OP_SEARCH_FWD, OP_SEARCH_REV, OP_SEL_PE, OP_SEL_GCR,
    OP_DIAG_INVOKE, OP_DIAG_LOOP_WR, OP_DIAG_STAT_SEQ, OP_DIAG_WRAP,
    OP_DIAG_EXT_SENSE, OP_DIAG_LOOPBACK, OP_ILLEGAL
  } tfcp_op_t;

  typedef enum logic [2:0] {PH_IDLE, PH_SPEED, PH_IDB, PH_XFER, PH_TAIL} tfcp_ph_t;

  // host lines, one bundle so they synchronise together
  typedef struct packed {
    logic fsel;
    logic [1:0] usel;
    logic start;
    logic offl;
    logic rew;
    logic fen;
    logic [4:0] cmd;
    logic [8:0] wdata;
    logic lastw;
    logic spd;
    logic gap;
  } tfcp_pins_t;
endpackage
`default_nettype wire

// File: hdl/tfcp_top.sv
/*
 * tape formatter command port: unit select, command capture and decode,
 * rewind/offline/enable handling, busy and id-burst outputs, write strobes.
 * assumes host lines asynchronous to core_clk_i and the tape mechanics
 * answering through same-clock done/level inputs.
 */
// The placing of the registers and the plain strobed port were left to the implementer.
// What this block does
// - formatter select low plus unit pair picks unit
// - capture command lines on start trailing edge
// - start during data busy ignored, overrun set
// - start ignored while unit offline
// - rewind drops ready, raises rewinding quickly
// - offline drops ready, online, rewinds, unloads
// - enable low stops motion, ends command
// - accepting a command clears status
// - speed select sets speed before read/write
// - long gap only in high speed
// - decode reads and spaces, 21 operations
// - decode the six diagnostic commands
// - decode the three write commands
// - formatter busy from start until completion
// - data busy only in transfer, queue next
// - id burst at beginning of tape
`default_nettype none
module tfcp_top
  import tfcp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire tfcp_pins_t host_i,
  input wire logic speed_done_i,
  input wire logic id_done_i,
  input wire logic rd_done_i,
  input wire logic motion_done_i,
  input wire logic rewind_done_i,
  input wire logic at_bot_i,
  input wire logic hard_err_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic formatter_busy_o,
  output logic data_busy_o,
  output logic id_burst_active_o,
  output logic unit_ready_o,
  output logic rewinding_status_o,
  output logic online_status_o,
  output logic hard_error_o,
  output logic high_speed_o,
  output logic long_gap_o,
  output logic write_data_strobe_o,
  output logic [8:0] wr_data_o,
  output logic wr_valid_o,
  output logic cmd_issue_o,
  output tfcp_op_t cmd_op_o,
  output logic speed_change_o,
  output logic stop_motion_o,
  output logic rewind_o,
  output logic unload_o
);
  typedef struct packed {
    tfcp_pins_t s1, s2, s3;
    tfcp_ph_t ph;
    logic armed, pend, pspd, pgap, spd_sel, busy, dbusy, overrun, herr;
    logic speed, longgap, online, loaded, rewinding, unload_pend;
    logic [4:0] cmd, pcmd;
    tfcp_op_t op;
    logic [1:0] unit_sw;
    logic wfirst, wstrobe, wvalid, issue, stop, rew, unload;
    logic [10:0] wcnt;
    logic [8:0] wdata;
    logic [31:0] rdata;
  } tfcp_st_t;

  tfcp_st_t q, d;
  logic [1:0] rs_q;
  logic rst_n;
  logic sel, st_lead, st_trail, st_ok, rw_lead, of_lead, rw_op, go, ovr;
  logic [4:0] gcmd;
  logic gspd, ggap;
  logic [10:0] wwid, wper;

  // command code to operation
  function automatic tfcp_op_t tfcp_decode(input logic [4:0] c);
    unique case (c)
      C_READ_FWD: tfcp_decode = OP_READ_FWD;
      C_READ_REV: tfcp_decode = OP_READ_REV;
      C_READ_SENSE: tfcp_decode = OP_READ_SENSE;
      C_SPACE_FWD: tfcp_decode = OP_SPACE_FWD;
      C_SPACE_REV: tfcp_decode = OP_SPACE_REV;
      C_SEARCH_FWD: tfcp_decode = OP_SEARCH_FWD;
      C_SEARCH_REV: tfcp_decode = OP_SEARCH_REV;
      C_SEL_PE: tfcp_decode = OP_SEL_PE;
      C_DIAG_INVOKE: tfcp_decode = OP_DIAG_INVOKE;
      C_DIAG_LOOP_WR: tfcp_decode = OP_DIAG_LOOP_WR;
      C_DIAG_STAT_SEQ: tfcp_decode = OP_DIAG_STAT_SEQ;
      C_DIAG_WRAP: tfcp_decode = OP_DIAG_WRAP;
      C_DIAG_EXT_SENSE: tfcp_decode = OP_DIAG_EXT_SENSE;
      C_DIAG_LOOPBACK: tfcp_decode = OP_DIAG_LOOPBACK;
      C_WRITE: tfcp_decode = OP_WRITE;
      C_WRITE_MARK: tfcp_decode = OP_WRITE_MARK;
      C_WRITE_EXT: tfcp_decode = OP_WRITE_EXT;
      C_ERASE_CTL: tfcp_decode = OP_ERASE_CTL;
      C_ERASE_FIX: tfcp_decode = OP_ERASE_FIX;
      C_ERASE_SEC: tfcp_decode = OP_ERASE_SEC;
      C_SEL_GCR: tfcp_decode = OP_SEL_GCR;
      default: tfcp_decode = OP_ILLEGAL;
    endcase
  endfunction

  // reset release through two flops
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rs_q <= 2'h0;
    else
      rs_q <= {rs_q[0], 1'b1};
  end
  assign rst_n = rs_q[1];

  // edge and qualifier terms on synchronised lines
  assign sel = !q.s2.fsel && (q.s2.usel == q.unit_sw);
  assign st_lead = q.s2.start && !q.s3.start;
  assign st_trail = !q.s2.start && q.s3.start;
  assign st_ok = sel && q.online && q.s2.fen && !q.dbusy;
  assign ovr = st_lead && (q.dbusy || q.s2.fsel);
  assign rw_lead = q.s2.rew && !q.s3.rew && sel && q.online && !q.busy;
  assign of_lead = q.s2.offl && !q.s3.offl && sel && q.online && !q.busy;
  assign rw_op = q.op inside {OP_READ_FWD, OP_READ_REV, OP_WRITE, OP_WRITE_EXT};
  assign wwid = q.speed ? 11'(WS_HI_WIDTH) : 11'(WS_LO_WIDTH);
  assign wper = q.speed ? 11'(WS_HI_PERIOD) : 11'(WS_LO_PERIOD);

  // next state
  always_comb
  begin
    d = q;
    go = 1'b0;
    gcmd = q.cmd;
    gspd = q.spd_sel;
    ggap = q.longgap;
    d.s1 = host_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.issue = 1'b0;
    d.wvalid = 1'b0;
    d.stop = 1'b0;
    d.rew = 1'b0;
    d.unload = 1'b0;
    d.rdata = 32'h0;
    // start strobe: leading edge arms, trailing edge captures
    if (ovr)
      d.overrun = 1'b1;
    else if (st_lead && st_ok)
    begin
      d.armed = 1'b1;
      d.busy = 1'b1;
    end
    if (st_trail && q.armed)
    begin
      d.armed = 1'b0;
      if (q.ph == PH_IDLE)
      begin
        go = 1'b1;
        gcmd = q.s2.cmd;
        gspd = q.s2.spd;
        ggap = q.s2.gap;
      end
      else
      begin
        d.pend = 1'b1;
        d.pcmd = q.s2.cmd;
        d.pspd = q.s2.spd;
        d.pgap = q.s2.gap;
      end
    end
    // command sequence
    unique case (q.ph)
      PH_IDLE: ;
      PH_SPEED:
        if (!rw_op)
          d.ph = PH_TAIL;
        else if (q.speed != q.spd_sel)
        begin
          if (speed_done_i)
            d.speed = q.spd_sel;
        end
        else if (at_bot_i)
          d.ph = PH_IDB;
        else
        begin
          d.ph = PH_XFER;
          d.dbusy = 1'b1;
          d.wfirst = 1'b1;
          d.wcnt = 11'h0;
        end
      PH_IDB:
        if (id_done_i)
        begin
          d.ph = PH_XFER;
          d.dbusy = 1'b1;
          d.wfirst = 1'b1;
          d.wcnt = 11'h0;
        end
      PH_XFER:
        if (q.op == OP_WRITE || q.op == OP_WRITE_EXT)
        begin
          // demand strobes until the host flags the last byte
          d.wcnt = q.wcnt + 11'h1;
          if (q.wfirst)
          begin
            if (q.wcnt == 11'(FIRST_DATA - 1))
            begin
              d.wfirst = 1'b0;
              d.wcnt = 11'h0;
            end
          end
          else
          begin
            d.wstrobe = (d.wcnt < wwid);
            if (q.wcnt == wper - 11'h1)
              d.wcnt = 11'h0;
            if (q.wcnt == wwid)
            begin
              d.wdata = q.s2.wdata;
              d.wvalid = 1'b1;
              if (q.s2.lastw)
              begin
                d.dbusy = 1'b0;
                d.wstrobe = 1'b0;
                d.ph = PH_TAIL;
              end
            end
          end
        end
        else if (rd_done_i)
        begin
          d.dbusy = 1'b0;
          d.ph = PH_TAIL;
        end
      PH_TAIL:
        if (motion_done_i)
        begin
          // next-state copy, so a start ending in this very cycle is not lost
          if (d.pend)
          begin
            go = 1'b1;
            d.pend = 1'b0;
            gcmd = d.pcmd;
            gspd = d.pspd;
            ggap = d.pgap;
          end
          else
          begin
            d.busy = 1'b0;
            d.ph = PH_IDLE;
          end
        end
    endcase
    if (hard_err_i)
      d.herr = 1'b1;
    // accept: decode, clear status, launch
    if (go)
    begin
      d.cmd = gcmd;
      d.op = tfcp_decode(gcmd);
      d.spd_sel = gspd;
      d.longgap = ggap && gspd;
      d.overrun = ovr; // a fresh overrun outranks the clear
      d.herr = hard_err_i;
      d.busy = 1'b1;
      d.issue = 1'b1;
      d.ph = PH_SPEED;
    end
    // enable dropped: stop motion and end the command
    if (q.online && !q.s2.fen && (q.busy || q.armed))
    begin
      d.ph = PH_IDLE;
      d.busy = 1'b0;
      d.dbusy = 1'b0;
      d.armed = 1'b0;
      d.pend = 1'b0;
      d.wstrobe = 1'b0;
      d.stop = 1'b1;
    end
    // rewind end first, so a new pulse in the same cycle wins
    if (rewind_done_i && q.rewinding)
    begin
      d.rewinding = 1'b0;
      d.unload_pend = 1'b0;
      if (q.unload_pend)
      begin
        d.loaded = 1'b0;
        d.unload = 1'b1;
      end
    end
    // rewind and offline pulses
    if (rw_lead && q.loaded)
    begin
      d.rewinding = 1'b1;
      d.rew = 1'b1;
    end
    if (of_lead)
    begin
      d.online = 1'b0;
      d.rewinding = 1'b1;
      d.unload_pend = 1'b1;
      d.rew = 1'b1;
    end
    // register port
    if (reg_wr_i && reg_addr_i == REG_CTRL)
    begin
      d.unit_sw = reg_wdata_i[1:0];
      d.online = reg_wdata_i[CTRL_ONLINE];
      d.loaded = reg_wdata_i[CTRL_LOADED];
    end
    if (reg_rd_i)
      unique case (reg_addr_i)
        REG_CTRL: d.rdata = {28'h0, q.loaded, q.online, q.unit_sw};
        REG_STAT: d.rdata = {21'h0, q.ph, q.rewinding, q.speed, q.herr,
          q.overrun, q.pend, q.dbusy, q.busy, unit_ready_o};
        REG_CMD: d.rdata = {20'h0, q.op, q.longgap, q.spd_sel, q.cmd};
        default: d.rdata = 32'h0;
      endcase
  end

  // state register
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.unit_sw <= UNIT_SW_RST;
      q.op <= OP_ILLEGAL;
    end
    else
      q <= d;
  end

  // status outputs, busy through high speed dark while offline; long gap and the rest not gated
  assign formatter_busy_o = q.busy && q.online;
  assign data_busy_o = q.dbusy && q.online;
  assign id_burst_active_o = (q.ph == PH_IDB) && q.online;
  assign unit_ready_o = q.online && q.loaded && !q.rewinding;
  assign rewinding_status_o = q.rewinding && q.online;
  assign online_status_o = q.online;
  assign hard_error_o = q.herr && q.online;
  assign high_speed_o = q.speed && q.online;
  assign long_gap_o = q.longgap;
  assign write_data_strobe_o = q.wstrobe;
  assign wr_data_o = q.wdata;
  assign wr_valid_o = q.wvalid;
  assign cmd_issue_o = q.issue;
  assign cmd_op_o = q.op;
  assign speed_change_o = (q.ph == PH_SPEED) && (q.speed != q.spd_sel);
  assign stop_motion_o = q.stop;
  assign rewind_o = q.rew;
  assign unload_o = q.unload;
  assign reg_rdata_o = q.rdata;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  property p_busy_start;
    st_lead && st_ok && !q.s2.fsel |=> q.busy;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy missed");
  property p_capture;
    st_trail && q.armed && q.ph == PH_IDLE && q.s2.fen |=> q.cmd == $past(q.s2.cmd) && q.issue;
  endproperty
  a_capture: assert property (p_capture) else $error("command not taken");
  property p_overrun;
    st_lead && q.dbusy |=> q.overrun && !q.issue;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed");
  property p_offline_start;
    st_lead && !q.online && !q.armed |=> !q.armed;
  endproperty
  a_offline_start: assert property (p_offline_start) else $error("offline start");
  property p_rewind;
    rw_lead && q.loaded |=> rewinding_status_o && !unit_ready_o;
  endproperty
  a_rewind: assert property (p_rewind) else $error("rewind late");
  property p_offline;
    of_lead |=> !q.online && q.rewinding ##0 !unit_ready_o;
  endproperty
  a_offline: assert property (p_offline) else $error("offline late");
  property p_enable;
    q.online && !q.s2.fen && q.busy |=> !q.busy && q.ph == PH_IDLE;
  endproperty
  a_enable: assert property (p_enable) else $error("enable abort");
  property p_dbusy;
    q.dbusy |-> q.ph == PH_XFER && q.speed == q.spd_sel;
  endproperty
  a_dbusy: assert property (p_dbusy) else $error("data busy phase");
  property p_gap;
    q.longgap |-> q.spd_sel;
  endproperty
  a_gap: assert property (p_gap) else $error("long gap at low speed");
  property p_clear;
    q.issue |-> q.overrun == $past(ovr) && q.op == tfcp_decode(q.cmd);
  endproperty
  a_clear: assert property (p_clear) else $error("status not cleared");
  c_last: cover property (q.wvalid && q.s3.lastw ##1 q.ph == PH_TAIL);
  c_overrun: cover property (st_lead && q.dbusy);
  c_queue: cover property (q.pend && motion_done_i && q.ph == PH_TAIL);
  c_unload: cover property (q.unload);
endmodule // tfcp_top
`default_nettype wire

// File: verif/tfcp_mech_model.sv
/*
 * tape mechanics stand-in: answers speed change, id burst, read end,
 * motion stop and rewind. assumes the core clock and active-high outputs.
 */
`default_nettype none
module tfcp_mech_model
  import tfcp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic issue_i,
  input wire logic dbusy_i,
  input wire logic spd_chg_i,
  input wire logic id_i,
  input wire logic rewind_i,
  input wire tfcp_op_t op_i,
  output logic speed_done_o,
  output logic id_done_o,
  output logic rd_done_o,
  output logic motion_done_o,
  output logic rewind_done_o,
  output logic at_bot_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  logic run;
  logic rw;
  logic rd;
  assign rd = dbusy_i && !(op_i inside {OP_WRITE, OP_WRITE_EXT});
  // one request at a time, id burst answered slowly, the rest promptly
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      {speed_done_o, id_done_o, rd_done_o, motion_done_o} <= 4'h0;
      {rewind_done_o, at_bot_o, run, rw} <= 4'h0;
      cnt <= 0;
    end
    else
    begin
      {speed_done_o, id_done_o, rd_done_o, motion_done_o, rewind_done_o} <= 5'h00;
      cnt <= cnt + 1;
      if (issue_i)
      begin
        run <= 1'b1;
        cnt <= 0;
      end
      else if (rewind_i)
      begin
        rw <= 1'b1;
        cnt <= 0;
      end
      else if (cnt >= (id_i ? 600 : 40))
      begin
        cnt <= 0;
        if (spd_chg_i)
          speed_done_o <= 1'b1;
        else if (id_i)
          id_done_o <= 1'b1;
        else if (rd)
          rd_done_o <= 1'b1; // read transfer ends
        else if (dbusy_i)
          cnt <= 0;
        else if (rw)
        begin
          rewind_done_o <= 1'b1; // tape back at start
          at_bot_o <= 1'b1;
          rw <= 1'b0;
        end
        else if (run)
        begin
          motion_done_o <= 1'b1;
          at_bot_o <= 1'b0;
          run <= 1'b0;
        end
      end
    end
  end
endmodule // tfcp_mech_model
`default_nettype wire

// File: verif/tb.sv
/*
 * self-checking bench for the command port: decode, write, overrun,
 * abort, speed, rewind, offline. assumes the mechanics stand-in model.
 */
`default_nettype none
module tb
  import tfcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, rws, rrs;
  tfcp_pins_t h;
  logic sdone, idone, rdone, mdone, wdone, bot;
  logic [7:0] ra;
  logic [31:0] rwd, rdata, v;
  logic fbusy, dbusy, idb, ready, rwnd, onl, hspd, lgap, wval, issue;
  logic spdchg, stopm, rewo, unld;
  logic herr, herro, wstb;
  logic [8:0] wdat;
  tfcp_op_t op;
  int bad_count = 0;
  int comparisons = 0;
  logic [4:0] codes [21] = '{C_READ_FWD, C_READ_REV, C_READ_SENSE, C_WRITE,
    C_WRITE_MARK, C_WRITE_EXT, C_ERASE_CTL, C_ERASE_FIX, C_ERASE_SEC,
    C_SPACE_FWD, C_SPACE_REV, C_SEARCH_FWD, C_SEARCH_REV, C_SEL_PE, C_SEL_GCR,
    C_DIAG_INVOKE, C_DIAG_LOOP_WR, C_DIAG_STAT_SEQ, C_DIAG_WRAP,
    C_DIAG_EXT_SENSE, C_DIAG_LOOPBACK};

  tfcp_top i_dut (.core_clk_i(clk), .rst_b_i(rst_b), .host_i(h),
    .speed_done_i(sdone), .id_done_i(idone), .rd_done_i(rdone),
    .motion_done_i(mdone), .rewind_done_i(wdone), .at_bot_i(bot), .hard_err_i(herr),
    .reg_addr_i(ra), .reg_wdata_i(rwd), .reg_wr_i(rws), .reg_rd_i(rrs),
    .reg_rdata_o(rdata), .formatter_busy_o(fbusy), .data_busy_o(dbusy),
    .id_burst_active_o(idb), .unit_ready_o(ready), .rewinding_status_o(rwnd),
    .online_status_o(onl), .hard_error_o(herro), .high_speed_o(hspd), .long_gap_o(lgap),
    .write_data_strobe_o(wstb), .wr_data_o(wdat), .wr_valid_o(wval), .cmd_issue_o(issue),
    .cmd_op_o(op), .speed_change_o(spdchg), .stop_motion_o(stopm), .rewind_o(rewo),
    .unload_o(unld));

  tfcp_mech_model i_mech (.clk_i(clk), .rst_b_i(rst_b), .issue_i(issue),
    .dbusy_i(dbusy), .spd_chg_i(spdchg), .id_i(idb), .rewind_i(rewo), .op_i(op),
    .speed_done_o(sdone), .id_done_o(idone), .rd_done_o(rdone),
    .motion_done_o(mdone), .rewind_done_o(wdone), .at_bot_o(bot));

  // clock, 5 ns period
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic test_done;
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // poll once a cycle, just after the edge, so pulses are not missed
  task automatic wt(ref logic s, input logic e, input int n, input string nm);
    for (int i = 0; i < n && s !== e; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk(nm, 32'(e), 32'(s));
  endtask

  task automatic rwr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    rwd <= d;
    rws <= 1'b1;
    @(posedge clk);
    rws <= 1'b0;
  endtask

  task automatic rrd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    ra <= a;
    rrs <= 1'b1;
    @(posedge clk);
    rrs <= 1'b0;
    #1;
    d = rdata;
  endtask

  // host start sequence: address and command settle, then a 1 us strobe
  task automatic cmd(input logic [4:0] c, input logic s, input logic g);
    @(posedge clk);
    h.cmd <= c;
    h.spd <= s;
    h.gap <= g;
    repeat (200) @(posedge clk); // address stable first
    h.start <= 1'b1;
    repeat (200) @(posedge clk); // strobe width
    h.start <= 1'b0;
    #1;
  endtask

  task automatic t_reset;
    chk("op", 32'(OP_ILLEGAL), 32'(op));
    chk("busy", 0, 32'(fbusy));
    rrd(REG_CTRL, v);
    chk("ctrl", 0, v);
    rwr(REG_CTRL, 32'hc);
    rrd(REG_CTRL, v);
    chk("ctrl", 32'hc, v);
    rrd(8'hfc, v);
    chk("unmapped", 0, v);
    wt(ready, 1'b1, 5, "ready");
  endtask

  task automatic t_write;
    h.lastw <= 1'b0;
    h.wdata <= 9'h105;
    cmd(C_WRITE, 1'b0, 1'b0);
    wt(dbusy, 1'b1, 20, "dbusy");
    cmd(C_READ_FWD, 1'b0, 1'b0); // start while data busy
    rrd(REG_STAT, v);
    chk("overrun", 1, 32'(v[4]));
    chk("op", 32'(OP_WRITE), 32'(op));
    for (int b = 0; b < 3; b++)
    begin
      wt(wstb, 1'b1, 3000, "strobe");
      wt(wval, 1'b1, 3000, "wvalid");
      chk("wdata", 32'(9'h105 + 9'(b * 37)), 32'(wdat));
      h.wdata <= 9'h105 + 9'((b + 1) * 37);
      h.lastw <= (b == 1);
      @(posedge clk);
      #1;
    end
    wt(dbusy, 1'b0, 20, "dbusy end");
    wt(fbusy, 1'b0, 200, "busy end");
  endtask

  task automatic t_decode;
    h.lastw <= 1'b1;
    h.usel <= 2'h1;
    cmd(C_READ_FWD, 1'b0, 1'b0);
    chk("other unit", 0, 32'(fbusy));
    for (int k = 0; k < 21; k++)
    begin
      rwr(REG_CTRL, 32'hc + 32'(k % 4));
      h.usel <= 2'(k % 4); // only while idle
      cmd(codes[k], 1'b0, 1'b0);
      wt(issue, 1'b1, 10, "issue");
      chk("busy", 1, 32'(fbusy));
      chk("op", 32'(k), 32'(op));
      if (k == 0)
      begin
        rrd(REG_STAT, v);
        chk("overrun clr", 0, 32'(v[4]));
      end
      wt(fbusy, 1'b0, 4000, "busy end");
    end
    rwr(REG_CTRL, 32'hc);
    h.usel <= 2'h0;
  endtask

  task automatic t_abort;
    h.lastw <= 1'b0;
    cmd(C_WRITE, 1'b0, 1'b0);
    wt(dbusy, 1'b1, 20, "dbusy");
    h.fen <= 1'b0;
    wt(stopm, 1'b1, 10, "stop");
    wt(fbusy, 1'b0, 10, "busy off");
    chk("dbusy", 0, 32'(dbusy));
    h.fen <= 1'b1;
    h.lastw <= 1'b1;
    repeat (50) @(posedge clk);
  endtask

  task automatic t_speed;
    herr <= 1'b1;
    @(posedge clk);
    herr <= 1'b0;
    #1;
    chk("hard err", 1, 32'(herro));
    cmd(C_READ_FWD, 1'b1, 1'b1);
    wt(spdchg, 1'b1, 20, "speed chg");
    chk("hard err clr", 0, 32'(herro));
    wt(hspd, 1'b1, 200, "high speed");
    chk("long gap", 1, 32'(lgap));
    wt(fbusy, 1'b0, 3000, "busy end");
    cmd(C_READ_FWD, 1'b0, 1'b1);
    wt(hspd, 1'b0, 200, "low speed");
    chk("long gap", 0, 32'(lgap));
    wt(fbusy, 1'b0, 3000, "busy end");
  endtask

  task automatic t_rewind;
    h.rew <= 1'b1;
    wt(rwnd, 1'b1, 200, "rewinding");
    chk("ready", 0, 32'(ready));
    repeat (200) @(posedge clk); // pulse held 1 us
    h.rew <= 1'b0;
    wt(rwnd, 1'b0, 300, "rewound");
    cmd(C_WRITE, 1'b0, 1'b0);
    wt(idb, 1'b1, 20, "id burst");
    wt(fbusy, 1'b0, 4000, "busy end");
  endtask

  task automatic t_offline;
    h.offl <= 1'b1;
    wt(ready, 1'b0, 200, "ready off");
    wt(unld, 1'b1, 150, "unload");
    repeat (200) @(posedge clk); // pulse held 1 us
    h.offl <= 1'b0;
    wt(onl, 1'b0, 100, "online off");
    cmd(C_READ_FWD, 1'b0, 1'b0);
    rrd(REG_STAT, v);
    chk("busy offline", 0, 32'(v[1]));
  endtask

  // hang guard, well above the expected run length
  initial
  begin
    repeat (100000) @(posedge clk);
    bad_count++;
    test_done;
  end

  initial
  begin
    h = '0;
    h.fen = 1'b1;
    {ra, rwd, rws, rrs, herr} = '0;
    rst_b = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    t_reset;
    t_write;
    t_decode;
    t_abort;
    t_speed;
    t_rewind;
    t_offline;
    test_done;
  end
endmodule // tb
`default_nettype wire
